// ### rtl/pfe_pkg.sv
package pfe_pkg;
	// ==========================================================
	// Register byte addresses
	localparam logic [11:0] ADDR_FLAGS_ONE   = 12'h0_000;
	localparam logic [11:0] ADDR_CC_FLAGS    = 12'h0_004;
	localparam logic [11:0] ADDR_EN_FIVE     = 12'h0_008;
	localparam logic [11:0] ADDR_EN_ONE      = 12'h0_00C;
	localparam logic [11:0] ADDR_EN_FOUR     = 12'h0_010;
	localparam logic [11:0] ADDR_FLAGS_FIVE  = 12'h0_014;
	localparam logic [11:0] ADDR_FLAGS_TWO   = 12'h0_018;
	localparam logic [11:0] ADDR_FLAGS_THREE = 12'h0_01C;
	localparam logic [11:0] ADDR_FLAGS_SIX   = 12'h0_020;
	localparam logic [11:0] ADDR_CTRL        = 12'h0_024;
	localparam logic [11:0] ADDR_IRQ_STATUS  = 12'h0_028;
	localparam logic [11:0] ADDR_IRQ_MASK    = 12'h0_02C;
	// ==========================================================
	// Field positions of the first flag register
	localparam int BIT_UNIMPL     = 7;
	localparam int BIT_CONV_DONE  = 6;
	localparam int BIT_RX_FULL    = 5;
	localparam int BIT_TX_EMPTY   = 4;
	localparam int BIT_SYNC_DONE  = 3;
	localparam int BIT_T1_GATE    = 2;
	localparam int BIT_T2_MATCH   = 1;
	localparam int BIT_T1_OVF     = 0;
	// Control register: bit 0 is the global interrupt enable
	localparam int BIT_GLOBAL_EN  = 0;
	// ==========================================================
	// Reset values and masks
	localparam logic [7:0] RESET_BYTE     = 8'h00;
	localparam logic [7:0] FLAGS_ONE_WMASK = 8'h4F;
	localparam logic [7:0] FULL_MASK      = 8'hFF;
	// Bits present on the small-memory variant
	localparam logic [7:0] CC_SMALL_MASK  = 8'h3F;
	localparam logic [7:0] EN5_SMALL_MASK = 8'h17;
	localparam logic [2:0] IRQ_RESET      = 3'h0;
	// Sticky event bits: 0 request rose, 1 unmapped access, 2 rx overrun
	localparam int EV_REQ_RISE = 0;
	localparam int EV_UNMAPPED = 1;
	localparam int EV_RX_OVR   = 2;
endpackage

// ### rtl/pfe_flag_bank.sv
`timescale 1ns/10ps
// Eight software-cleared sticky flags; set wins over a write of zero
module pfe_flag_bank #(
	parameter logic [7:0] IMPL_MASK = 8'hFF
) (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Events and software write
	input  wire logic [7:0] set_evt,
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_data,
	// Flag state
	output logic      [7:0] flags
);
	// ==========================================================
	// State
	typedef struct packed {
		logic [7:0] flags_reg;
	} pfe_bank_st_t;

	pfe_bank_st_t st_reg;
	pfe_bank_st_t st_next;

	// Next-state: writes store, events set afterwards
	always_comb begin
		st_next = st_reg;
		if (wr_en) begin
			st_next.flags_reg = wr_data;
		end
		st_next.flags_reg = (st_next.flags_reg | set_evt) & IMPL_MASK;
	end

	// Registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign flags = st_reg.flags_reg;
endmodule

// ### rtl/pfe_irq_regs.sv
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/10ps
// ==========================================================
// Notes on behaviour
// - A flag sets on its source event whatever its enable and the global enable hold.
// - Six peripheral flag registers exist to cover every source.
// - Bit 7 of the first flag register reads zero and ignores writes.
// - The converter-done flag in bit 6 sets on conversion end and holds until written zero.
// - The read-only receive flag in bit 5 is high while the receive buffer holds data.
// - The read-only transmit flag in bit 4 is high while the transmit buffer is empty.
// - The sync port flag in bit 3 sets when a transfer ends and holds until cleared.
// - The timer-one gate flag in bit 2 sets on a gate event and only software clears it.
// - The timer-two match flag in bit 1 sets on a period match and holds until cleared.
// - The timer-one overflow flag in bit 0 sets on overflow and holds until written zero.
// - On the small-memory variant the top capture flags and marked enables are absent.
// - Enable bit 6 of the fifth enable register gates the timer-twelve match request.
// - Enable bit 5 of the fifth enable register gates the timer-ten match request.
module pfe_irq_regs #(
	parameter bit SMALL_MEMORY = 1'b0
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Events into the first flag register, one-cycle pulses
	input  wire logic        conv_done_evt,
	input  wire logic        sync_done_evt,
	input  wire logic        t1_gate_evt,
	input  wire logic        t2_match_evt,
	input  wire logic        t1_ovf_evt,
	// Serial buffer status and accesses
	input  wire logic        rx_data_evt,
	input  wire logic        rx_buf_read,
	input  wire logic        tx_buf_write,
	input  wire logic        tx_done_evt,
	// Other event groups
	input  wire logic [7:0]  capcomp_evt,
	input  wire logic [7:0]  timer_evt_five,
	input  wire logic [7:0]  evt_two,
	input  wire logic [7:0]  evt_three,
	input  wire logic [7:0]  evt_six,
	// Requests
	output logic             periph_irq,
	output logic             irq
);
	// ==========================================================
	// State
	typedef struct packed {
		logic       rx_full;
		logic       tx_empty;
		logic [7:0] en_one;
		logic [7:0] en_four;
		logic [7:0] en_five;
		logic       global_en;
		logic [2:0] ev_status;
		logic [2:0] ev_mask;
		logic       req_prev;
		logic [31:0] rdata;
	} pfe_state_t;

	pfe_state_t st_reg;
	pfe_state_t st_next;

	localparam logic [7:0] CC_MASK =
		SMALL_MEMORY ? pfe_pkg::CC_SMALL_MASK : pfe_pkg::FULL_MASK;
	localparam logic [7:0] EN5_MASK =
		SMALL_MEMORY ? pfe_pkg::EN5_SMALL_MASK : pfe_pkg::FULL_MASK;

	// Widen a byte into a bus word
	function automatic logic [31:0] pfe_word(input logic [7:0] b);
		pfe_word = {24'h00_0000, b};
	endfunction

	// ==========================================================
	// Bus decode
	logic        acc;
	logic        wr;
	logic        rd;
	logic        mapped;
	logic [7:0]  wbyte;

	assign acc   = psel & penable;
	assign wr    = acc & pwrite;
	assign rd    = acc & ~pwrite;
	assign wbyte = pwdata[7:0];

	// Address map check
	always_comb begin
		case (paddr)
			pfe_pkg::ADDR_FLAGS_ONE, pfe_pkg::ADDR_CC_FLAGS, pfe_pkg::ADDR_EN_FIVE,
			pfe_pkg::ADDR_EN_ONE, pfe_pkg::ADDR_EN_FOUR, pfe_pkg::ADDR_FLAGS_FIVE,
			pfe_pkg::ADDR_FLAGS_TWO, pfe_pkg::ADDR_FLAGS_THREE, pfe_pkg::ADDR_FLAGS_SIX,
			pfe_pkg::ADDR_CTRL, pfe_pkg::ADDR_IRQ_STATUS,
			pfe_pkg::ADDR_IRQ_MASK: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// ==========================================================
	// Flag banks
	logic [7:0] f1_sw;
	logic [7:0] f1_set;
	logic [7:0] cc_flags;
	logic [7:0] f2;
	logic [7:0] f3;
	logic [7:0] f5;
	logic [7:0] f6;
	logic [7:0] flags_one;

	// Software-cleared bits of the first register
	assign f1_set = {1'b0, conv_done_evt, 2'b00, sync_done_evt,
		t1_gate_evt, t2_match_evt, t1_ovf_evt};

	pfe_flag_bank #(.IMPL_MASK(pfe_pkg::FLAGS_ONE_WMASK)) u_f1 (
		.pclk    (pclk),
		.presetn (presetn),
		.set_evt (f1_set),
		.wr_en   (wr && paddr == pfe_pkg::ADDR_FLAGS_ONE),
		.wr_data (wbyte),
		.flags   (f1_sw)
	);

	pfe_flag_bank #(.IMPL_MASK(CC_MASK)) u_f4 (
		.pclk    (pclk),
		.presetn (presetn),
		.set_evt (capcomp_evt),
		.wr_en   (wr && paddr == pfe_pkg::ADDR_CC_FLAGS),
		.wr_data (wbyte),
		.flags   (cc_flags)
	);

	pfe_flag_bank u_f2 (
		.pclk    (pclk),
		.presetn (presetn),
		.set_evt (evt_two),
		.wr_en   (wr && paddr == pfe_pkg::ADDR_FLAGS_TWO),
		.wr_data (wbyte),
		.flags   (f2)
	);

	pfe_flag_bank u_f3 (
		.pclk    (pclk),
		.presetn (presetn),
		.set_evt (evt_three),
		.wr_en   (wr && paddr == pfe_pkg::ADDR_FLAGS_THREE),
		.wr_data (wbyte),
		.flags   (f3)
	);

	pfe_flag_bank u_f5 (
		.pclk    (pclk),
		.presetn (presetn),
		.set_evt (timer_evt_five),
		.wr_en   (wr && paddr == pfe_pkg::ADDR_FLAGS_FIVE),
		.wr_data (wbyte),
		.flags   (f5)
	);

	pfe_flag_bank u_f6 (
		.pclk    (pclk),
		.presetn (presetn),
		.set_evt (evt_six),
		.wr_en   (wr && paddr == pfe_pkg::ADDR_FLAGS_SIX),
		.wr_data (wbyte),
		.flags   (f6)
	);

	// Assemble first register; bit 7 always zero
	assign flags_one = {1'b0, f1_sw[pfe_pkg::BIT_CONV_DONE], st_reg.rx_full,
		st_reg.tx_empty, f1_sw[3:0]};

	// ==========================================================
	// Request to the core
	logic req;
	logic [7:0] en5_sel;

	// Fifth enables each gate one timer source of the fifth flags
	assign en5_sel = f5 & st_reg.en_five;
	assign req = st_reg.global_en &
		(|(flags_one & st_reg.en_one) | |(cc_flags & st_reg.en_four) |
		|en5_sel);

	// ==========================================================
	// Next-state logic
	logic [2:0] ev_set;

	always_comb begin
		st_next  = st_reg;
		ev_set   = 3'h0;
		// Receive buffer full: load sets, buffer read clears
		if (rx_buf_read) begin
			st_next.rx_full = 1'b0;
		end
		if (rx_data_evt) begin
			st_next.rx_full = 1'b1;
		end
		// Transmit buffer empty: write clears, shift-out sets
		if (tx_buf_write) begin
			st_next.tx_empty = 1'b0;
		end
		if (tx_done_evt) begin
			st_next.tx_empty = 1'b1;
		end
		// Register writes
		if (wr) begin
			case (paddr)
				pfe_pkg::ADDR_EN_ONE:   st_next.en_one  = wbyte & pfe_pkg::FLAGS_ONE_WMASK |
					wbyte & 8'h30;
				pfe_pkg::ADDR_EN_FOUR:  st_next.en_four = wbyte & CC_MASK;
				pfe_pkg::ADDR_EN_FIVE:  st_next.en_five = wbyte & EN5_MASK;
				pfe_pkg::ADDR_CTRL:     st_next.global_en = pwdata[pfe_pkg::BIT_GLOBAL_EN];
				pfe_pkg::ADDR_IRQ_MASK: st_next.ev_mask = pwdata[2:0];
				pfe_pkg::ADDR_IRQ_STATUS: st_next.ev_status = st_reg.ev_status & ~pwdata[2:0];
				default: ;
			endcase
		end
		// Sticky events; set wins over clear
		ev_set[pfe_pkg::EV_REQ_RISE] = req & ~st_reg.req_prev;
		ev_set[pfe_pkg::EV_UNMAPPED] = acc & ~mapped;
		ev_set[pfe_pkg::EV_RX_OVR]   = rx_data_evt & st_reg.rx_full & ~rx_buf_read;
		st_next.ev_status = st_next.ev_status | ev_set;
		st_next.req_prev  = req;
		// Read data captured at setup, presented in the access cycle
		case (paddr)
			pfe_pkg::ADDR_FLAGS_ONE:   st_next.rdata = pfe_word(flags_one);
			pfe_pkg::ADDR_CC_FLAGS:    st_next.rdata = pfe_word(cc_flags);
			pfe_pkg::ADDR_EN_FIVE:     st_next.rdata = pfe_word(st_reg.en_five);
			pfe_pkg::ADDR_EN_ONE:      st_next.rdata = pfe_word(st_reg.en_one);
			pfe_pkg::ADDR_EN_FOUR:     st_next.rdata = pfe_word(st_reg.en_four);
			pfe_pkg::ADDR_FLAGS_FIVE:  st_next.rdata = pfe_word(f5);
			pfe_pkg::ADDR_FLAGS_TWO:   st_next.rdata = pfe_word(f2);
			pfe_pkg::ADDR_FLAGS_THREE: st_next.rdata = pfe_word(f3);
			pfe_pkg::ADDR_FLAGS_SIX:   st_next.rdata = pfe_word(f6);
			pfe_pkg::ADDR_CTRL:        st_next.rdata = {31'h0000_0000, st_reg.global_en};
			pfe_pkg::ADDR_IRQ_STATUS:  st_next.rdata = {29'h0000_0000, st_reg.ev_status};
			pfe_pkg::ADDR_IRQ_MASK:    st_next.rdata = {29'h0000_0000, st_reg.ev_mask};
			default:                   st_next.rdata = 32'h0000_0000;
		endcase
	end

	// Registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg          <= '0;
			st_reg.tx_empty <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// Outputs
	assign pready     = 1'b1;
	assign pslverr    = acc & ~mapped;
	assign prdata     = (rd & mapped) ? st_reg.rdata : 32'h0000_0000;
	assign periph_irq = st_reg.req_prev;
	assign irq        = |(st_reg.ev_status & st_reg.ev_mask);
endmodule

// ### test/pfe_checker.sv
`timescale 1ns/10ps
// ==========================================================
// Port checker of the flag and enable block
module pfe_checker (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Events
	input wire logic        conv_done_evt,
	input wire logic        sync_done_evt,
	input wire logic        t1_gate_evt,
	input wire logic        t2_match_evt,
	input wire logic        t1_ovf_evt,
	input wire logic        rx_data_evt,
	input wire logic        rx_buf_read,
	input wire logic        tx_buf_write,
	input wire logic        tx_done_evt,
	// Request
	input wire logic        periph_irq
);
	logic [7:0] f1_q;
	logic       rx_q;
	logic       tx_q;
	logic       ge_q;
	logic       acc;
	logic       map;
	logic       rd;
	logic [7:0] evt;
	// Access decode and event byte
	assign acc = psel & penable;
	assign rd  = acc & ~pwrite;
	assign map = (paddr <= pfe_pkg::ADDR_IRQ_MASK) && (paddr[1:0] == 2'b00);
	assign evt = {1'b0, conv_done_evt, 2'b00, sync_done_evt, t1_gate_evt, t2_match_evt, t1_ovf_evt};
	// Shadow of first flag register and global enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			f1_q <= 8'h00;
			rx_q <= 1'b0;
			tx_q <= 1'b1;
			ge_q <= 1'b0;
		end else begin
			if (acc && pwrite && paddr == pfe_pkg::ADDR_FLAGS_ONE)
				f1_q <= (pwdata[7:0] & pfe_pkg::FLAGS_ONE_WMASK) | evt;
			else
				f1_q <= f1_q | evt;
			if (acc && pwrite && paddr == pfe_pkg::ADDR_CTRL)
				ge_q <= pwdata[pfe_pkg::BIT_GLOBAL_EN];
			rx_q <= rx_data_evt | (rx_q & ~rx_buf_read);
			tx_q <= tx_done_evt | (tx_q & ~tx_buf_write);
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================================
	// Assertions
	a_ready_high: assert property (pready) else $error("pready low");
	a_err_unmapped: assert property (acc && !map |-> pslverr) else $error("no slverr");
	a_err_mapped: assert property (acc && map |-> !pslverr) else $error("slverr on map");
	a_rdata_idle: assert property (!psel |-> prdata == 32'h0000_0000) else $error("rdata idle");
	a_err_rd_zero: assert property (rd && !map |-> prdata == 32'h0000_0000) else $error("err rdata");
	a_flags_one_rd: assert property (rd && paddr == pfe_pkg::ADDR_FLAGS_ONE |->
		prdata == {25'h0, $past(f1_q[6]), $past(rx_q), $past(tx_q), $past(f1_q[3:0])})
		else $error("flags one read");
	a_req_needs_ge: assert property (periph_irq |-> $past(ge_q)) else $error("req w/o ge");
	a_ctrl_rd: assert property (rd && paddr == pfe_pkg::ADDR_CTRL |->
		prdata == {31'h0, $past(ge_q)}) else $error("ctrl read");
endmodule

bind pfe_irq_regs pfe_checker i_pfe_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .conv_done_evt(conv_done_evt),
	.sync_done_evt(sync_done_evt), .t1_gate_evt(t1_gate_evt), .t2_match_evt(t2_match_evt),
	.t1_ovf_evt(t1_ovf_evt), .rx_data_evt(rx_data_evt), .rx_buf_read(rx_buf_read),
	.tx_buf_write(tx_buf_write), .tx_done_evt(tx_done_evt), .periph_irq(periph_irq));

// ### test/pfe_evt_src.sv
`timescale 1ns/10ps
// ==========================================================
// Event source model: one-cycle pulses on command
module pfe_evt_src (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Command from bench
	input  wire logic        go,
	input  wire logic [3:0]  sel,
	input  wire logic [7:0]  data,
	// Pulses and their byte
	output logic      [13:0] p,
	output logic      [7:0]  v
);
	// Pulse stands one cycle, low between commands
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p <= 14'h0000;
			v <= 8'h00;
		end else begin
			p <= go ? (14'h0001 << sel) : 14'h0000;
			v <= go ? data : ~v;
		end
	end
endmodule

// ### test/pfe_irq_regs_tb_top.sv
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module pfe_irq_regs_tb_top;
	// Bench signals
	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h0000_0000;
	logic        go      = 1'b0;
	logic [3:0]  sel     = 4'h0;
	logic [7:0]  data    = 8'h00;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        periph_irq;
	logic        irq;
	logic [13:0] p;
	logic [7:0]  v;
	logic [31:0] rd;
	logic [31:0] prdata_s;
	logic [31:0] rd_s;
	logic        err;
	logic [31:0] rnd;
	logic [7:0]  r8;
	int          fails      = 0;
	int          num_checks = 0;
	int          i;
	// Clock
	always #2.5 pclk = ~pclk;
	// Design and event sources
	pfe_irq_regs i_pfe_irq_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .conv_done_evt(p[0]), .sync_done_evt(p[1]), .t1_gate_evt(p[2]),
		.t2_match_evt(p[3]), .t1_ovf_evt(p[4]), .rx_data_evt(p[5]), .rx_buf_read(p[6]),
		.tx_buf_write(p[7]), .tx_done_evt(p[8]), .capcomp_evt(p[9] ? v : 8'h00),
		.timer_evt_five(p[10] ? v : 8'h00), .evt_two(p[11] ? v : 8'h00),
		.evt_three(p[12] ? v : 8'h00), .evt_six(p[13] ? v : 8'h00),
		.periph_irq(periph_irq), .irq(irq));
	pfe_evt_src i_pfe_evt_src (.pclk(pclk), .presetn(presetn), .go(go), .sel(sel), .data(data),
		.p(p), .v(v));
	// Small-memory variant sharing every input
	pfe_irq_regs #(.SMALL_MEMORY(1'b1)) i_pfe_irq_regs_small (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata_s), .pready(), .pslverr(), .conv_done_evt(p[0]), .sync_done_evt(p[1]),
		.t1_gate_evt(p[2]), .t2_match_evt(p[3]), .t1_ovf_evt(p[4]), .rx_data_evt(p[5]),
		.rx_buf_read(p[6]), .tx_buf_write(p[7]), .tx_done_evt(p[8]),
		.capcomp_evt(p[9] ? v : 8'h00), .timer_evt_five(p[10] ? v : 8'h00),
		.evt_two(p[11] ? v : 8'h00), .evt_three(p[12] ? v : 8'h00),
		.evt_six(p[13] ? v : 8'h00), .periph_irq(), .irq());
	// One APB transfer, waits for pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		rd_s = prdata_s;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// One event command
	task automatic fire(input logic [3:0] s, input logic [7:0] d);
		@(posedge pclk);
		go <= 1'b1;
		sel <= s;
		data <= d;
		@(posedge pclk);
		go <= 1'b0;
	endtask
	// Let registered outputs land
	task automatic settle;
		repeat (2) @(posedge pclk);
		#1;
	endtask
	// Expected first flag register
	function automatic logic [31:0] f1(input logic [7:0] s, input logic rx, input logic tx);
		return {25'h0, s[6], rx, tx, s[3:0]};
	endfunction
	// Verdict
	task automatic report_and_stop;
		if (fails == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Watchdog
	initial begin
		#20000;
		fails++;
		report_and_stop;
	end
	// Main sequence
	initial begin
		rnd = $urandom(32'h867ba30f);
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values of every mapped register
		for (i = 0; i < 12; i++) begin
			apb(1'b0, 12'(i * 4), 32'h0000_0000);
			`CHK({err, rd}, {1'b0, f1(8'h00, 1'b0, i == 0)})
		end
		apb(1'b1, 12'h030, 32'hFFFF_FFFF);
		apb(1'b0, 12'h030, 32'h0000_0000);
		`CHK({err, rd}, {1'b1, 32'h0000_0000})
		// Read-only and unimplemented bits of the first flag register
		apb(1'b1, pfe_pkg::ADDR_FLAGS_ONE, 32'h0000_00FF);
		apb(1'b0, pfe_pkg::ADDR_FLAGS_ONE, 32'h0000_0000);
		`CHK(rd, f1(8'hFF, 1'b0, 1'b1))
		apb(1'b1, pfe_pkg::ADDR_FLAGS_ONE, 32'h0000_0000);
		// Each source sets its flag, writing zero clears it
		for (i = 0; i < 5; i++) begin
			fire(4'(i), 8'h00);
			apb(1'b0, pfe_pkg::ADDR_FLAGS_ONE, 32'h0000_0000);
			`CHK(rd, f1((i == 0) ? 8'h40 : 8'(8'h08 >> (i - 1)), 1'b0, 1'b1))
			apb(1'b1, pfe_pkg::ADDR_FLAGS_ONE, 32'h0000_0000);
		end
		fire(4'd5, 8'h00);
		fire(4'd7, 8'h00);
		apb(1'b0, pfe_pkg::ADDR_FLAGS_ONE, 32'h0000_0000);
		`CHK(rd, f1(8'h00, 1'b1, 1'b0))
		fire(4'd6, 8'h00);
		fire(4'd8, 8'h00);
		apb(1'b0, pfe_pkg::ADDR_FLAGS_ONE, 32'h0000_0000);
		`CHK(rd, f1(8'h00, 1'b0, 1'b1))
		// Random capture flags and fifth enables
		for (i = 0; i < 8; i++) begin
			rnd = $urandom;
			r8 = 8'($urandom);
			apb(1'b1, pfe_pkg::ADDR_CC_FLAGS, rnd);
			fire(4'd9, r8);
			apb(1'b0, pfe_pkg::ADDR_CC_FLAGS, 32'h0000_0000);
			`CHK(rd, {24'h0, rnd[7:0] | r8})
			`CHK(rd_s, {24'h0, (rnd[7:0] | r8) & pfe_pkg::CC_SMALL_MASK})
			apb(1'b1, pfe_pkg::ADDR_EN_FIVE, {rnd[31:8], r8});
			apb(1'b0, pfe_pkg::ADDR_EN_FIVE, 32'h0000_0000);
			`CHK(rd, {24'h0, r8})
			`CHK(rd_s, {24'h0, r8 & pfe_pkg::EN5_SMALL_MASK})
			// Second, third and sixth flag registers in turn
			apb(1'b1, 12'(pfe_pkg::ADDR_FLAGS_TWO + 4 * (i % 3)), rnd);
			fire(4'(11 + i % 3), r8);
			apb(1'b0, 12'(pfe_pkg::ADDR_FLAGS_TWO + 4 * (i % 3)), 32'h0000_0000);
			`CHK(rd, {24'h0, rnd[7:0] | r8})
		end
		// Request needs flag, enable and global enable
		apb(1'b1, pfe_pkg::ADDR_EN_FIVE, 32'h0000_0040);
		fire(4'd10, 8'h40);
		settle;
		`CHK(periph_irq, 1'b0)
		apb(1'b1, pfe_pkg::ADDR_CTRL, 32'h0000_0001);
		settle;
		`CHK(periph_irq, 1'b1)
		for (i = 5; i < 7; i++) begin
			apb(1'b1, pfe_pkg::ADDR_FLAGS_FIVE, 32'h0000_0000);
			apb(1'b1, pfe_pkg::ADDR_EN_FIVE, 32'(1 << i));
			fire(4'd10, 8'(1 << (11 - i)));
			settle;
			`CHK(periph_irq, 1'b0)
			fire(4'd10, 8'(1 << i));
			settle;
			`CHK(periph_irq, 1'b1)
		end
		// First and capture flag groups behind their own enables
		apb(1'b1, pfe_pkg::ADDR_FLAGS_FIVE, 32'h0000_0000);
		apb(1'b1, pfe_pkg::ADDR_CC_FLAGS, 32'h0000_0000);
		apb(1'b1, pfe_pkg::ADDR_EN_ONE, 32'h0000_0010);
		settle;
		`CHK(periph_irq, 1'b1)
		apb(1'b1, pfe_pkg::ADDR_EN_ONE, 32'h0000_0040);
		settle;
		`CHK(periph_irq, 1'b0)
		fire(4'd0, 8'h00);
		settle;
		`CHK(periph_irq, 1'b1)
		apb(1'b1, pfe_pkg::ADDR_FLAGS_ONE, 32'h0000_0000);
		apb(1'b1, pfe_pkg::ADDR_EN_FOUR, 32'h0000_0080);
		settle;
		`CHK(periph_irq, 1'b0)
		fire(4'd9, 8'h80);
		settle;
		`CHK(periph_irq, 1'b1)
		apb(1'b1, pfe_pkg::ADDR_CTRL, 32'h0000_0000);
		settle;
		`CHK(periph_irq, 1'b0)
		// Sticky status, mask and level interrupt
		apb(1'b0, pfe_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
		`CHK(rd, 32'h0000_0003)
		apb(1'b1, pfe_pkg::ADDR_IRQ_MASK, 32'h0000_0002);
		settle;
		`CHK(irq, 1'b1)
		apb(1'b1, pfe_pkg::ADDR_IRQ_STATUS, 32'h0000_0002);
		settle;
		`CHK(irq, 1'b0)
		fire(4'd5, 8'h00);
		fire(4'd5, 8'h00);
		apb(1'b1, pfe_pkg::ADDR_IRQ_MASK, 32'h0000_0004);
		settle;
		`CHK(irq, 1'b1)
		apb(1'b1, pfe_pkg::ADDR_IRQ_STATUS, 32'h0000_0007);
		apb(1'b0, pfe_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
		`CHK({irq, rd}, {1'b0, 32'h0000_0000})
		// Reset in mid-run
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, pfe_pkg::ADDR_FLAGS_ONE, 32'h0000_0000);
		`CHK(rd, f1(8'h00, 1'b0, 1'b1))
		report_and_stop;
	end
endmodule
